// ---- rtl/ddc_params.svh ----
`ifndef DDC_PARAMS_SVH
`define DDC_PARAMS_SVH
`define DDC_ADDR_DATAPATH_CONTROL 5'h00
`define DDC_RESET_DATAPATH_CONTROL 8'h70
`define DDC_BIT_OFFSET_ENA 7
`define DDC_BIT_FIFO_ENA 6
`define DDC_BIT_WR_RESET_ENA 5
`define DDC_BIT_SYNC_ENA 4
`define DDC_BIT_ALERT_OE 3
`define DDC_BIT_ALERT_POL 2
`define DDC_MIX_HI 1
`define DDC_MIX_LO 0
`define DDC_SHIFT_TOP 15
`endif

// ---- rtl/ddc_pkg.sv ----
package ddc_pkg;
  typedef enum logic [1:0] {
    DDC_MIX_NORMAL,
    DDC_MIX_HALF,
    DDC_MIX_PLUS_QUARTER,
    DDC_MIX_MINUS_QUARTER
  } ddc_mix_t;
endpackage

// ---- rtl/ddc_sync2.sv ----
`timescale 1ns/1ps
module ddc_sync2 (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // asynchronous level in, synchronised level out
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ---- rtl/ddc_datapath_control.sv ----
`timescale 1ns/1ps
`include "ddc_params.svh"
// Summary of operation
// RQ1 - control register sits at address 0x00 and resets to 0x70
// RQ2 - bit 7 set adds the digital offset to data; clear adds none
// RQ3 - bit 6 set routes samples via the input FIFO; clear bypasses it
// RQ4 - bit 5 set lets word-sync reset the FIFO write pointer
// RQ5 - bit 4 set enables multi-device sync from word-sync or strobe
// RQ6 - separate source-select bit picks word-sync or output strobe
// RQ7 - bit 3 set drives the shared alert/serial-out pin as alarm
// RQ8 - bit 2 sets alarm polarity; one means active high
// RQ9 - bits 1:0 pick coarse mixer: none, fs/2, +fs/4, -fs/4
// RQ10 - host writes before streaming; reads return last written value
module ddc_datapath_control (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register access port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // other configuration inputs
  input  wire logic        chip_sync_source_select,
  input  wire logic [15:0] offset_value,
  // pins
  input  wire logic        word_sync_pin,
  input  wire logic        output_strobe_input,
  input  wire logic        alarm_event,
  input  wire logic        serial_out_data,
  input  wire logic        serial_out_oe,
  output logic             alert_serial_out_pin_o,
  output logic             alert_serial_out_pin_oe,
  // datapath
  input  wire logic [15:0] sample_in,
  input  wire logic        sample_valid,
  input  wire logic [15:0] fifo_sample,
  output logic      [15:0] sample_out,
  output logic             use_fifo,
  output logic             fifo_wr_reset,
  output logic             multi_sync
);
  import ddc_pkg::*;

  logic [7:0]  ctrl_r;
  logic [1:0]  phase_r;
  logic        ws_s;
  logic        os_s;
  ddc_mix_t    mix;
  logic        sel_hit;
  logic [15:0] pre_mix;
  logic [15:0] mixed;
  logic        neg_now;

  ddc_sync2 u_ws (
    .core_clk (core_clk),
    .rst      (rst),
    .d        (word_sync_pin),
    .q        (ws_s)
  );
  ddc_sync2 u_os (
    .core_clk (core_clk),
    .rst      (rst),
    .d        (output_strobe_input),
    .q        (os_s)
  );

  function automatic logic [15:0] neg16(input logic [15:0] v);
    neg16 = 16'(~v + 16'h0001);
  endfunction

  assign sel_hit = (reg_addr == `DDC_ADDR_DATAPATH_CONTROL); // see RQ1
  assign mix = ddc_mix_t'(ctrl_r[`DDC_MIX_HI:`DDC_MIX_LO]);
  // see RQ3: pick FIFO output or bypass, then RQ2 offset add
  // wrap-around add: the carry out is dropped on purpose
  assign pre_mix = 16'((ctrl_r[`DDC_BIT_FIFO_ENA] ? fifo_sample : sample_in)
                 + (ctrl_r[`DDC_BIT_OFFSET_ENA] ? offset_value : 16'h0000));
  // sign pattern of each mixer mode over a four-sample cycle
  always_comb begin
    case (mix) // see RQ9
      DDC_MIX_NORMAL:        neg_now = 1'b0;
      DDC_MIX_HALF:          neg_now = phase_r[0];
      DDC_MIX_PLUS_QUARTER:  neg_now = phase_r[1];
      DDC_MIX_MINUS_QUARTER: neg_now = phase_r[1] ^ phase_r[0];
      default:               neg_now = 1'b0;
    endcase
  end
  // real-only approximation; the complex rotation lives in the mixer
  assign mixed = neg_now ? neg16(pre_mix) : pre_mix;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `DDC_RESET_DATAPATH_CONTROL; // see RQ1
    end else if (reg_wr && sel_hit) begin
      ctrl_r <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= sel_hit ? ctrl_r : 8'h00; // see RQ10
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_r    <= 2'h0;
      sample_out <= 16'h0000;
    end else if (sample_valid) begin
      phase_r    <= 2'(phase_r + 2'h1);
      sample_out <= mixed;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      use_fifo      <= 1'b0;
      fifo_wr_reset <= 1'b0;
      multi_sync    <= 1'b0;
    end else begin
      use_fifo      <= ctrl_r[`DDC_BIT_FIFO_ENA]; // see RQ3
      fifo_wr_reset <= ctrl_r[`DDC_BIT_WR_RESET_ENA] & ws_s; // see RQ4
      multi_sync    <= ctrl_r[`DDC_BIT_SYNC_ENA] &
                       (chip_sync_source_select ? os_s : ws_s); // see RQ5 RQ6
    end
  end

  // pin is shared with serial readback; alarm owns it when enabled
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alert_serial_out_pin_o  <= 1'b0;
      alert_serial_out_pin_oe <= 1'b0;
    end else if (ctrl_r[`DDC_BIT_ALERT_OE]) begin // see RQ7
      alert_serial_out_pin_o  <= ~(alarm_event ^
                                   ctrl_r[`DDC_BIT_ALERT_POL]); // see RQ8
      alert_serial_out_pin_oe <= 1'b1;
    end else begin
      alert_serial_out_pin_o  <= serial_out_data;
      alert_serial_out_pin_oe <= serial_out_oe;
    end
  end
endmodule

// ---- verif/ddc_host_model.sv ----
`timescale 1ns/1ps
module ddc_host (
  input  wire logic       core_clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [4:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // one access per call, held across the taking edge
  task acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge core_clk);
    {reg_wr, reg_rd} = 2'h0;
  endtask
endmodule

// ---- verif/ddc_datapath_control_props.sv ----
`timescale 1ns/1ps
module ddc_chk (
  input wire logic core_clk, rst, reg_wr, reg_rd, sample_valid,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata,
  input wire logic chip_sync_source_select, word_sync_pin, alarm_event,
  input wire logic output_strobe_input, use_fifo, fifo_wr_reset,
  input wire logic alert_serial_out_pin_o, alert_serial_out_pin_oe,
  input wire logic multi_sync,
  input wire logic [15:0] offset_value, sample_in, sample_out
);
  logic [7:0] c_r;
  logic       up_r;
  // outputs still hold reset values at the first edge after release
  always_ff @(posedge core_clk or posedge rst)
    if (rst) up_r <= 1'b0;
    else up_r <= 1'b1;
  always_ff @(posedge core_clk or posedge rst)
    if (rst) c_r <= 8'h70;
    else if (reg_wr && reg_addr == 5'h00) c_r <= reg_wdata;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  fifo_sel_a: assert property (up_r |-> use_fifo == $past(c_r[6]))
    else $error("fifo select");
  wr_reset_a: assert property (fifo_wr_reset ==
    ($past(c_r[5]) && $past(word_sync_pin, 3))) else $error("wr reset");
  chip_sync_a: assert property (multi_sync == ($past(c_r[4]) &&
    ($past(chip_sync_source_select) ? $past(output_strobe_input, 3) :
    $past(word_sync_pin, 3)))) else $error("sync");
  alert_oe_a: assert property ($past(c_r[3]) |->
    alert_serial_out_pin_oe) else $error("alert enable");
  alert_pol_a: assert property ($past(c_r[3]) |->
    alert_serial_out_pin_o == ($past(alarm_event) ~^ $past(c_r[2])))
    else $error("alert level");
  rd_back_a: assert property (reg_rd && reg_addr == 5'h00 |=>
    reg_rdata == $past(c_r)) else $error("readback");
  rd_unmap_a: assert property (reg_rd && reg_addr != 5'h00 |=>
    reg_rdata == 8'h00) else $error("unmapped read");
  offset_add_a: assert property (sample_valid && c_r == 8'h80 |=>
    sample_out == 16'($past(sample_in) + $past(offset_value)))
    else $error("offset");
endmodule
bind ddc_datapath_control ddc_chk u_chk (.*);

// ---- verif/ddc_datapath_control_tb.sv ----
`timescale 1ns/1ps
module ddc_datapath_control_tb;
  logic core_clk = 0, rst = 1, css = 0, ws = 0, os = 0, ev = 0, sv = 0;
  logic [15:0] ofs = 16'h0100, si = 16'h1234, so, fs = 16'h0000;
  logic sod = 0, soe = 0;
  logic reg_wr, reg_rd, pin_o, pin_oe, use_fifo, wrr, ms;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int err_count = 0, checks = 0;
  ddc_host host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  ddc_datapath_control dut (.core_clk, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .chip_sync_source_select(css),
    .offset_value(ofs), .word_sync_pin(ws), .output_strobe_input(os),
    .alarm_event(ev), .serial_out_data(sod), .serial_out_oe(soe),
    .alert_serial_out_pin_o(pin_o), .alert_serial_out_pin_oe(pin_oe),
    .sample_in(si), .sample_valid(sv), .fifo_sample(fs),
    .sample_out(so), .use_fifo, .fifo_wr_reset(wrr), .multi_sync(ms));
  initial forever #5 core_clk = ~core_clk;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e);
    host.acc(0, a, 8'h00);
    chk(16'(reg_rdata), 16'(e));
  endtask
  task t_regs;
    rd(5'h00, 8'h70);
    for (int i = 0; i < 8; i++) begin
      host.acc(1, 5'h00, 8'h01 << i);
      rd(5'h00, 8'h01 << i);
    end
    host.acc(1, 5'h03, 8'hFF);
    rd(5'h03, 8'h00);
    rd(5'h00, 8'h80);
    $display("registers done");
  endtask
  task t_pins;
    host.acc(1, 5'h00, 8'h70);
    ws = 1;
    repeat (4) @(negedge core_clk);
    chk({wrr, ms}, 2'h3);
    {ws, os, css} = 3'h3;
    repeat (4) @(negedge core_clk);
    chk({wrr, ms, use_fifo}, 3'h3);
    host.acc(1, 5'h00, 8'h00);
    @(negedge core_clk);
    chk({ms, use_fifo}, 2'h0);
    $display("sync pins done");
  endtask
  task t_alarm;
    host.acc(1, 5'h00, 8'h0C);
    ev = 1;
    repeat (2) @(negedge core_clk);
    chk({pin_oe, pin_o}, 2'h3);
    host.acc(1, 5'h00, 8'h08);
    @(negedge core_clk);
    chk({pin_oe, pin_o}, 2'h2);
    $display("alarm done");
  endtask
  task t_ofs;
    host.acc(1, 5'h00, 8'h80);
    sv = 1;
    @(negedge core_clk);
    sv = 0;
    @(negedge core_clk);
    chk(so, 16'h1334);
    $display("offset done");
  endtask
  // phase counter stands at 1 here: one valid sample so far
  task t_mix;
    {fs, sod, soe} = {16'h0ABC, 2'h3};
    host.acc(1, 5'h00, 8'h41);
    sv = 1;
    @(negedge core_clk);
    chk(so, 16'hF544);
    chk({use_fifo, pin_oe, pin_o}, 3'h7);
    @(negedge core_clk);
    chk(so, 16'h0ABC);
    sv = 0;
    host.acc(1, 5'h00, 8'h02);
    sv = 1;
    @(negedge core_clk);
    chk(so, 16'hEDCC);
    @(negedge core_clk);
    chk(so, 16'h1234);
    sv = 0;
    $display("mixer done");
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    rst = 0;
    t_regs;
    t_pins;
    t_alarm;
    t_ofs;
    t_mix;
    final_report;
  end
  initial begin
    #20000;
    err_count++;
    final_report;
  end
endmodule
